// File: core/expander_master.sv
// two-wire bus master driving the expander, AXI4-Lite controlled
`timescale 1ns/1ps
`include "expander_params.svh"
module expander_master import expander_pkg::*; #(
  parameter int HALF_BIT = `HALF_BIT_CYC
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  two_wire_if.master bus // two-wire link
);
  master_state_e st_q;
  logic [31:0] awaddr_q, wdata_q, ctrl_q, wbuf_q;
  logic aw_q, w_q;
  logic [7:0] rdata_q;
  logic [15:0] cnt_q;
  logic [5:0] bit_q;
  logic [27:0] frame_q;
  logic nack_q, rd_q, busy_q, scl_q, sda_q, sda_oe_q, rst_n_q;
  logic [1:0] sda_sync_q;

  always_ff @(posedge aclk) begin
    sda_sync_q <= {sda_sync_q[0], bus.sda};
  end

  wire do_write = aw_q && w_q && !s_axi_bvalid;
  wire w_ctrl = do_write && awaddr_q[7:0] == `REG_CTRL;
  wire w_wdata = do_write && awaddr_q[7:0] == `REG_WDATA;
  wire go = w_ctrl && wbuf_q[`CTRL_GO_BIT] && !busy_q;
  wire tick = cnt_q == 16'(HALF_BIT - 1);
  wire [31:0] status = {22'h0, nack_q, rdata_q, busy_q};
  wire [31:0] rd_val = s_axi_araddr[7:0] == `REG_CTRL ? ctrl_q : s_axi_araddr[7:0] == `REG_WDATA ? wdata_q :
                       s_axi_araddr[7:0] == `REG_STATUS ? status : s_axi_araddr[7:0] == `REG_RDATA ? {24'h0, rdata_q} : 32'h0;
  wire wr_ok = awaddr_q[7:0] == `REG_CTRL || awaddr_q[7:0] == `REG_WDATA;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      ctrl_q <= 32'h0;
      wbuf_q <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wbuf_q <= s_axi_wdata;
      end
      // commit only once both address and data are in hand
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      if (w_ctrl) begin
        ctrl_q <= wbuf_q;
      end
      if (w_wdata) begin
        wdata_q <= wbuf_q;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_val == 32'h0 && s_axi_araddr[7:0] > `REG_RDATA ? 2'h2 : 2'h0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // frame: addr+w, cmd, then either data or restart addr+r and one read byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= M_IDLE;
      cnt_q <= 16'h0;
      bit_q <= 6'h0;
      frame_q <= 28'h0;
      nack_q <= 1'b0;
      rd_q <= 1'b0;
      busy_q <= 1'b0;
      rdata_q <= 8'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_oe_q <= 1'b0;
      rst_n_q <= 1'b1;
    end else begin
      cnt_q <= tick ? 16'h0 : cnt_q + 16'h1;
      case (st_q)
        M_IDLE: begin
          cnt_q <= 16'h0;
          if (go && wbuf_q[`CTRL_RST_BIT]) begin
            st_q <= M_RST;
            busy_q <= 1'b1;
            rst_n_q <= 1'b0;
            bit_q <= 6'(`RESET_PULSE_CYC + `RESET_COMPLETE_CYC);
          end else if (go) begin
            st_q <= M_START;
            busy_q <= 1'b1;
            rd_q <= wbuf_q[`CTRL_READ_BIT];
            nack_q <= 1'b0;
            frame_q <= {`ADDR_FIXED, wdata_q[18:16], 1'b0, 1'b1, 6'h0, wdata_q[9:8], 1'b1, wdata_q[7:0], 1'b1, 1'b1};
            bit_q <= 6'h0;
          end
        end
        M_RST: begin
          if (bit_q == 6'(`RESET_COMPLETE_CYC)) begin
            rst_n_q <= 1'b1;
          end
          if (bit_q == 6'h0) begin
            st_q <= M_DONE;
          end else begin
            bit_q <= bit_q - 6'h1;
          end
        end
        M_START, M_RSTART: begin
          if (tick) begin
            if (!scl_q) begin
              scl_q <= 1'b1;
              sda_oe_q <= 1'b0;
            end else if (sda_oe_q == 1'b0) begin
              sda_q <= 1'b0;
              sda_oe_q <= 1'b1;
            end else begin
              // bit count runs on across a repeated start
              scl_q <= 1'b0;
              st_q <= M_BIT;
            end
          end
        end
        M_BIT: begin
          if (tick) begin
            if (!scl_q) begin
              scl_q <= 1'b1;
            end else begin
              scl_q <= 1'b0;
              if (bit_q % 9 == 8 && sda_sync_q[1] && !(rd_q && bit_q == 6'd35)) begin
                nack_q <= 1'b1;
              end
              if (rd_q && bit_q >= 6'd27 && bit_q < 6'd35) begin
                rdata_q <= {rdata_q[6:0], sda_sync_q[1]};
              end
              bit_q <= bit_q + 6'h1;
              if ((!rd_q && bit_q == 6'd26) || bit_q == 6'd35) begin
                st_q <= M_STOP;
              end else if (rd_q && bit_q == 6'd17) begin
                st_q <= M_RSTART;
                frame_q <= {`ADDR_FIXED, wdata_q[18:16], 1'b1, 1'b1, 19'h7FFFF};
              end
            end
          end else if (!scl_q && cnt_q == 16'h0) begin
            // release for acks, nack last read byte
            sda_q <= rd_q && bit_q >= 6'd18 ? frame_q[5'(6'd45 - bit_q)] : frame_q[5'(6'd27 - bit_q)];
            sda_oe_q <= 1'b1;
          end
        end
        M_STOP: begin
          if (tick) begin
            if (sda_oe_q && sda_q) begin
              sda_q <= 1'b0;
            end else if (!scl_q) begin
              scl_q <= 1'b1;
            end else begin
              sda_oe_q <= 1'b0;
              sda_q <= 1'b1;
              st_q <= M_DONE;
            end
          end
        end
        M_DONE: begin
          busy_q <= 1'b0;
          st_q <= M_IDLE;
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  assign bus.scl_o = scl_q;
  assign bus.scl_oe = !scl_q;
  assign bus.m_sda_o = sda_q;
  assign bus.m_sda_oe = sda_oe_q && !sda_q;
  assign bus.reset_n = rst_n_q;
  // straps held from the write data register
  assign bus.addr_select_pins = wdata_q[18:16];
endmodule // expander_master

// File: core/expander_params.svh
// constants for the two-wire port expander and its bus master
`ifndef EXPANDER_PARAMS_SVH
`define EXPANDER_PARAMS_SVH
`define ADDR_FIXED 4'h3
`define CMD_INPUT 2'h0
`define CMD_OUTPUT 2'h1
`define CMD_POLARITY 2'h2
`define CMD_CONFIG 2'h3
`define OUT_RESET 8'h00
`define POL_RESET 8'hF0
`define CFG_RESET 8'hFF
`define RESET_PULSE_MIN_NS 16
`define RESET_COMPLETE_NS 400
`define CLK_PERIOD_NS 100
`define RESET_PULSE_CYC ((`RESET_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_COMPLETE_CYC ((`RESET_COMPLETE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_CYC 4
`define HALF_BIT_CYC 4
`define REG_CTRL 32'h0000_0000
`define REG_WDATA 32'h0000_0004
`define REG_STATUS 32'h0000_0008
`define REG_RDATA 32'h0000_000C
`define CTRL_GO_BIT 0
`define CTRL_READ_BIT 1
`define CTRL_RST_BIT 2
`endif

// File: core/expander_pkg.sv
// types shared by the expander and its master
package expander_pkg;
  typedef enum logic [4:0] {
    SL_IDLE = 5'h01, SL_SHIFT = 5'h02, SL_ACK = 5'h04, SL_SEND = 5'h08, SL_WAITACK = 5'h10
  } slave_state_e;
  typedef enum logic [2:0] {
    PH_ADDR = 3'h1, PH_CMD = 3'h2, PH_DATA = 3'h4
  } phase_e;
  typedef enum logic [6:0] {
    M_IDLE = 7'h01, M_START = 7'h02, M_BIT = 7'h04, M_STOP = 7'h08, M_RST = 7'h10, M_DONE = 7'h20,
    M_RSTART = 7'h40
  } master_state_e;
endpackage

// File: core/expander_slave.sv
// two-wire port expander slave with reset handling
// Summary of operation
// - reset pin held low at least 16 ns
// - allow 400 ns for reset completion
// - reset pin low holds registers at default
// - power-on reset holds until supply ready
// - any reset makes every port input
// - master starts only on idle bus
// - start is data falling, clock high
// - address shifted msb first, direction last
// - matching address acknowledged with data low
// - address straps steady start to stop
// - data change during clock high is control
// - stop is data rising, clock high
// - bytes are eight bits plus acknowledge
// - transmitter releases data before acknowledge
// - receiver acknowledges; master nacks last byte
// - on nack device releases data line
// - address 0011, straps, then direction bit
// - port byte bit n is line n
// - command low bits select register
// - defaults: out 00, polarity F0, config FF
// - config one is input, zero output
// - last command keeps selecting for reads
`timescale 1ns/1ps
`include "expander_params.svh"
module expander_slave import expander_pkg::*; (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  two_wire_if.device bus, // two-wire link
  input wire logic [7:0] port_in, // port pin levels
  output logic [7:0] port_out, // port output levels
  output logic [7:0] port_oe // port output enables
);
  logic [1:0] scl_sync_q, sda_sync_q, rst_sync_q;
  logic scl_q, sda_q;
  logic [$clog2(`POR_CYC+1)-1:0] por_cnt_q;
  slave_state_e state_q;
  phase_e phase_q;
  logic [7:0] shift_q, out_q, pol_q, cfg_q, tx_q;
  logic [3:0] bit_q;
  logic rw_q, sda_o_q, sda_oe_q;
  logic [1:0] cmd_q;
  logic [7:0] port_in_q1, port_in_q2;
  logic [2:0] strap_q1, strap_q2;

  // pin inputs pass two flops first
  always_ff @(posedge aclk) begin
    scl_sync_q <= {scl_sync_q[0], bus.scl};
    sda_sync_q <= {sda_sync_q[0], bus.sda};
    rst_sync_q <= {rst_sync_q[0], bus.reset_n};
    port_in_q1 <= port_in;
    port_in_q2 <= port_in_q1;
    strap_q1 <= bus.addr_select_pins;
    strap_q2 <= strap_q1;
    scl_q <= scl_sync_q[1];
    sda_q <= sda_sync_q[1];
  end

  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_det = scl_s && scl_q && sda_q && !sda_s;
  wire stop_det = scl_s && scl_q && !sda_q && sda_s;
  // data sampled on clock rise only
  wire [7:0] shift_next = {shift_q[6:0], sda_s};
  // address compare
  // full address byte sits in shift_q once the eighth clock has fallen
  wire addr_match = shift_q[7:4] == `ADDR_FIXED && shift_q[3:1] == strap_q2;
  wire por_active = por_cnt_q != '0;
  wire dev_rst = !aresetn || !rst_sync_q[1] || por_active;
  // read mux, bit n is line n
  wire [7:0] rd_mux = cmd_q == `CMD_INPUT ? (port_in_q2 ^ pol_q) :
                      cmd_q == `CMD_OUTPUT ? out_q : cmd_q == `CMD_POLARITY ? pol_q : cfg_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_q <= ($clog2(`POR_CYC+1))'(`POR_CYC);
    end else if (por_active) begin
      por_cnt_q <= por_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      state_q <= SL_IDLE;
      phase_q <= PH_ADDR;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      rw_q <= 1'b0;
      cmd_q <= `CMD_INPUT;
      out_q <= `OUT_RESET;
      pol_q <= `POL_RESET;
      cfg_q <= `CFG_RESET;
      tx_q <= 8'h00;
      sda_o_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      state_q <= SL_SHIFT;
      phase_q <= PH_ADDR;
      bit_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= SL_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        SL_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        SL_SHIFT: begin
          if (scl_rise) begin
            shift_q <= shift_next;
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (phase_q == PH_ADDR && !addr_match) begin
              // not ours, wait for next start
              state_q <= SL_IDLE;
            end else begin
              state_q <= SL_ACK;
              sda_o_q <= 1'b0;
              sda_oe_q <= 1'b1;
              if (phase_q == PH_ADDR) begin
                rw_q <= shift_q[0];
              end else if (phase_q == PH_CMD) begin
                cmd_q <= shift_q[1:0];
              end else begin
                case (cmd_q)
                  `CMD_OUTPUT: out_q <= shift_q;
                  `CMD_POLARITY: pol_q <= shift_q;
                  `CMD_CONFIG: cfg_q <= shift_q;
                  default: ;
                endcase
              end
            end
          end
        end
        SL_ACK: begin
          if (scl_fall) begin
            if (phase_q == PH_ADDR && rw_q) begin
              state_q <= SL_SEND;
              tx_q <= {rd_mux[6:0], 1'b0};
              sda_o_q <= rd_mux[7];
              sda_oe_q <= 1'b1;
              bit_q <= 4'h1;
              phase_q <= PH_DATA;
            end else begin
              state_q <= SL_SHIFT;
              sda_oe_q <= 1'b0;
              phase_q <= phase_q == PH_ADDR ? PH_CMD : PH_DATA;
            end
          end
        end
        SL_SEND: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              state_q <= SL_WAITACK;
              sda_oe_q <= 1'b0;
              bit_q <= 4'h0;
            end else begin
              sda_o_q <= tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        SL_WAITACK: begin
          if (scl_rise) begin
            // nack ends sending, line stays released
            if (sda_s) begin
              state_q <= SL_IDLE;
            end else begin
              state_q <= SL_ACK;
              rw_q <= 1'b1;
              phase_q <= PH_ADDR;
            end
          end
        end
        default: state_q <= SL_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      port_out <= `OUT_RESET;
      port_oe <= 8'h00;
    end else begin
      port_out <= out_q;
      port_oe <= ~cfg_q;
    end
  end

  assign bus.s_sda_o = sda_o_q;
  assign bus.s_sda_oe = sda_oe_q;
endmodule // expander_slave

// File: core/two_wire_if.sv
// two-wire bus, address straps and reset pin between master and expander
`timescale 1ns/1ps
interface two_wire_if;
  logic scl_o; // master clock drive
  logic scl_oe; // master drives clock low
  logic m_sda_o; // master data drive
  logic m_sda_oe; // master data enable
  logic s_sda_o; // expander data drive
  logic s_sda_oe; // expander data enable
  logic reset_n; // expander reset pin
  logic [2:0] addr_select_pins; // address straps
  wire scl = !(scl_oe && !scl_o);
  wire sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
  modport master (output scl_o, scl_oe, m_sda_o, m_sda_oe, reset_n, addr_select_pins, input scl, sda);
  modport device (input scl, sda, reset_n, addr_select_pins, output s_sda_o, s_sda_oe);
endinterface

// File: sim/expander_asserts.sv
// link checks for the two-wire expander and its master
`timescale 1ns/1ps
module expander_asserts (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic scl, // resolved clock line
  input wire logic sda, // resolved data line
  input wire logic s_sda_o, // expander data drive
  input wire logic s_sda_oe, // expander data enable
  input wire logic reset_n, // expander reset pin
  input wire logic [2:0] addr_select_pins // address straps
);
  logic scl_q, sda_q, first_q, rd_q, hit_q, frame_q;
  logic [3:0] cnt_q;
  logic [7:0] byte_q;
  wire start_w = scl && scl_q && sda_q && !sda;
  wire stop_w = scl && scl_q && !sda_q && sda;
  wire rise_w = scl && !scl_q;
  wire slot_w = rise_w && cnt_q == 4'h8;
  wire [6:0] want_w = {4'h3, addr_select_pins};
  wire pull_w = s_sda_oe && !s_sda_o;
  // bit counter, byte shifter and frame tracking
  always_ff @(posedge aclk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!aresetn || start_w) begin
      cnt_q <= 4'h0;
      first_q <= 1'b1;
    end else if (slot_w) begin
      cnt_q <= 4'h0;
      first_q <= 1'b0;
    end else if (rise_w) begin
      cnt_q <= cnt_q + 4'h1;
    end
    if (rise_w && cnt_q < 4'h8) byte_q <= {byte_q[6:0], sda};
    if (slot_w && first_q) rd_q <= byte_q[0];
    if (slot_w && first_q) hit_q <= !sda;
    if (!aresetn || stop_w) frame_q <= 1'b0;
    else if (start_w) frame_q <= 1'b1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_pin_reset_quiet: assert property ((!reset_n) [*2] |-> ##2 (!s_sda_oe) [*2])
    else $error("expander drives data while reset pin low");
  chk_por_quiet: assert property ($rose(aresetn) |-> (!s_sda_oe) [*4])
    else $error("expander drives data during power-on hold");
  chk_data_steady: assert property (scl && scl_q && reset_n |-> $stable(pull_w))
    else $error("expander changed data while clock high");
  chk_ack_held: assert property (slot_w && !sda |-> (!sda) [*4])
    else $error("acknowledge not held through clock high");
  chk_addr_match_ack: assert property (slot_w && first_q && !sda |-> byte_q[7:1] == want_w)
    else $error("address acknowledged without a match");
  chk_addr_miss_quiet: assert property (slot_w && first_q && byte_q[7:1] != want_w |-> !s_sda_oe)
    else $error("mismatched address acknowledged");
  chk_write_byte_ack: assert property (slot_w && !first_q && hit_q && !rd_q |-> !sda)
    else $error("received byte not acknowledged");
  chk_read_release: assert property (slot_w && !first_q && rd_q |-> !s_sda_oe)
    else $error("expander holds data in master acknowledge slot");
  chk_stop_quiet: assert property (stop_w |-> !s_sda_oe)
    else $error("expander drives data at stop");
  chk_straps_steady: assert property (frame_q |-> $stable(addr_select_pins))
    else $error("address straps changed inside a frame");
  chk_reset_wait: assert property ($rose(reset_n) |-> (!start_w) [*4])
    else $error("frame started too soon after pin reset");
endmodule // expander_asserts

// File: sim/io_expander_i2c_slave_reset_test.sv
// self-checking bench for the expander and its bus master
`timescale 1ns/1ps
`include "expander_params.svh"
module io_expander_i2c_slave_reset_test import expander_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] port_in = 8'h00, port_out, port_oe;
  logic [2:0] straps = 3'h0;
  int mismatches = 0;
  int total_checks = 0;
  two_wire_if bus_if ();
  expander_master i_expander_master (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .bus(bus_if));
  expander_slave i_expander_slave (.aclk, .aresetn, .bus(bus_if), .port_in, .port_out, .port_oe);
  expander_asserts i_expander_asserts (.aclk, .aresetn, .scl(bus_if.scl), .sda(bus_if.sda),
    .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe), .reset_n(bus_if.reset_n),
    .addr_select_pins(bus_if.addr_select_pins));
  always #50 aclk = ~aclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (aw_left && s_axi_awready === 1'b1) begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1) begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // one frame on the link, then wait until the master is idle
  task automatic link(input logic rd, input logic [1:0] cmd, input logic [7:0] data, output logic [7:0] rbyte);
    logic [31:0] st;
    logic [1:0] resp;
    int n;
    axi_wr(`REG_WDATA, {13'h0, straps, 6'h0, cmd, data}, resp);
    axi_wr(`REG_CTRL, {30'h0, rd, 1'b1}, resp);
    n = 0;
    do begin
      axi_rd(`REG_STATUS, st, resp);
      n++;
    end while (st[0] !== 1'b0 && n < 400);
    rbyte = st[8:1];
    check(st[0], 1'b0);
    check(st[9], 1'b0);
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask
  task automatic t_defaults();
    logic [7:0] dflt [4] = '{8'h00, `OUT_RESET, `POL_RESET, `CFG_RESET};
    logic [7:0] rb;
    check({port_oe, port_out}, 16'h0000);
    for (int c = 1; c < 4; c++) begin
      link(1'b1, c[1:0], 8'h00, rb);
      check(rb, dflt[c]);
    end
  endtask
  task automatic t_write_dir();
    logic [7:0] rb;
    straps = 3'h5;
    link(1'b0, `CMD_OUTPUT, 8'hA5, rb);
    check(port_out, 8'hA5);
    check(port_oe, 8'h00);
    link(1'b0, `CMD_CONFIG, 8'h0F, rb);
    check(port_oe, 8'hF0);
    link(1'b1, `CMD_CONFIG, 8'h00, rb);
    check(rb, 8'h0F);
  endtask
  task automatic t_input_pol();
    logic [7:0] rb;
    port_in <= 8'h3C;
    link(1'b0, `CMD_POLARITY, 8'h81, rb);
    link(1'b1, `CMD_INPUT, 8'h00, rb);
    check(rb, 8'hBD);
  endtask
  task automatic t_all_straps();
    logic [7:0] rb;
    for (int s = 0; s < 8; s++) begin
      straps = s[2:0];
      link(1'b1, `CMD_CONFIG, 8'h00, rb);
      check(rb, 8'h0F);
    end
  endtask
  task automatic t_pin_reset();
    logic [1:0] resp;
    logic [7:0] rb;
    axi_wr(`REG_CTRL, 32'h0000_0005, resp);
    repeat (12) @(posedge aclk);
    check({port_oe, port_out}, 16'h0000);
    link(1'b1, `CMD_POLARITY, 8'h00, rb);
    check(rb, `POL_RESET);
  endtask
  task automatic t_sys_reset();
    logic [7:0] rb;
    link(1'b0, `CMD_OUTPUT, 8'h5A, rb);
    link(1'b0, `CMD_CONFIG, 8'h00, rb);
    check({port_oe, port_out}, 16'hFF5A);
    do_reset();
    check({port_oe, port_out}, 16'h0000);
    link(1'b1, `CMD_CONFIG, 8'h00, rb);
    check(rb, `CFG_RESET);
  endtask
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] resp;
    axi_rd(32'h0000_0010, d, resp);
    check(d, 32'h0000_0000);
    check(resp, 2'h2);
    axi_wr(32'h0000_0014, 32'h0000_00FF, resp);
    check(resp, 2'h2);
  endtask
  initial begin
    #5_000_000;
    mismatches++;
    finish_test();
  end
  initial begin
    do_reset();
    t_defaults();
    t_write_dir();
    t_input_pol();
    t_all_straps();
    t_pin_reset();
    t_sys_reset();
    t_unmapped();
    finish_test();
  end
endmodule // io_expander_i2c_slave_reset_test
